// ---- opmc_pkg.sv ----
package opmc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SETF = 8'h08;
  localparam logic [ADDR_W-1:0] REG_OUTF = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_MON = 8'h10;
  localparam logic [ADDR_W-1:0] REG_WARN = 8'h14;

  // Control fields
  localparam int CTRL_STOP_BIT = 0;
  localparam int CTRL_JOG_BIT = 1;
  localparam int CTRL_CUST_BIT = 2;
  localparam int CTRL_UNIT_LSB = 4;
  localparam int UNIT_W = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0077;

  // Status fields
  localparam int STAT_CODE_LSB = 0;
  localparam int STAT_GROUP_LSB = 8;
  localparam int STAT_LEVEL_LSB = 12;
  localparam int STAT_DIGIT_LSB = 16;
  localparam int STAT_MODE_LSB = 20;
  localparam int STAT_EDIT_BIT = 24;

  // Unit lamp selections
  localparam logic [UNIT_W-1:0] UNIT_HZ = 3'h0;
  localparam logic [UNIT_W-1:0] UNIT_AMP = 3'h1;
  localparam logic [UNIT_W-1:0] UNIT_VOLT = 3'h2;
  localparam logic [UNIT_W-1:0] UNIT_RPM = 3'h3;
  localparam logic [UNIT_W-1:0] UNIT_PCT = 3'h4;

  // Command sources
  localparam logic [1:0] SRC_KEYPAD = 2'h0;
  localparam logic [1:0] SRC_TERMINAL = 2'h1;
  localparam logic [1:0] SRC_COMM = 2'h2;

  // Display geometry
  localparam int DIGITS = 5;
  localparam int DIGIT_W = 4;
  localparam int VAL_W = DIGITS * DIGIT_W;
  localparam int GROUP_W = 4;
  localparam int CODE_W = 8;
  localparam logic [2:0] DIGIT_LAST = 3'h4;
  localparam logic [1:0] VIEW_LAST = 2'h2;
  localparam logic [1:0] DMODE_LAST = 2'h2;

  // Timing
  localparam int CLK_NS = 10;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_NS;
  localparam int FAST_HALF_MS = 100;
  localparam int SLOW_HALF_MS = 500;
  localparam int EDIT_HALF_MS = 250;
  localparam int BLINK_CNT_W = 10;

  typedef enum logic [1:0] {
    LVL_STATUS,
    LVL_GROUP,
    LVL_CODE,
    LVL_VALUE
  } opmc_level_e;

  typedef struct packed {
    logic prog;
    logic enter;
    logic up;
    logic down;
    logic shift;
    logic run;
    logic stop;
    logic mode;
    logic jog;
  } opmc_key_s;

  typedef struct packed {
    logic running;
    logic fault;
    logic tuning;
    logic torque_mode;
    logic dir_fwd;
    logic [1:0] cmd_src;
    logic param_readonly;
    logic param_stop_only;
  } opmc_drive_s;

  typedef struct packed {
    logic run_lamp;
    logic control_source_lamp;
    logic direction_lamp;
    logic tune_torque_fault_lamp;
    logic hz_lamp;
    logic amp_lamp;
    logic volt_lamp;
  } opmc_lamp_s;

  typedef struct packed {
    logic run_cmd;
    logic stop_cmd;
    logic fault_reset;
    logic jog_cmd;
    logic dir_reverse;
  } opmc_cmd_s;

endpackage

// ---- opmc_panel.sv ----
`timescale 1ns/100ps
`default_nettype none
module opmc_panel #(
  parameter int TICK_CYCLES = opmc_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [opmc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire opmc_pkg::opmc_key_s keys,
  input wire opmc_pkg::opmc_drive_s drive,
  input wire logic [opmc_pkg::VAL_W-1:0] param_value,
  output opmc_pkg::opmc_lamp_s lamps,
  output opmc_pkg::opmc_cmd_s cmds,
  output logic [opmc_pkg::VAL_W-1:0] disp_value,
  output logic [opmc_pkg::DIGITS-1:0] disp_blank,
  output logic [opmc_pkg::GROUP_W-1:0] sel_group,
  output logic [opmc_pkg::CODE_W-1:0] sel_code,
  output logic store_we,
  output logic [opmc_pkg::VAL_W-1:0] store_value,
  output logic [1:0] display_mode
);

  localparam int VW = opmc_pkg::VAL_W;
  localparam int TW = $clog2(TICK_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  logic [31:0] ctrl_r;
  logic [VW-1:0] setf_r;
  logic [VW-1:0] outf_r;
  logic [VW-1:0] mon_r;
  logic [VW-1:0] warn_r;
  logic [31:0] prdata_r;
  logic [31:0] status_w;
  logic [31:0] rd_mux;
  logic hit_ctrl, hit_status, hit_setf, hit_outf, hit_mon, hit_warn, hit_any;
  logic wr_en, setup_rd;

  assign hit_ctrl = paddr == opmc_pkg::REG_CTRL;
  assign hit_status = paddr == opmc_pkg::REG_STATUS;
  assign hit_setf = paddr == opmc_pkg::REG_SETF;
  assign hit_outf = paddr == opmc_pkg::REG_OUTF;
  assign hit_mon = paddr == opmc_pkg::REG_MON;
  assign hit_warn = paddr == opmc_pkg::REG_WARN;
  assign hit_any = hit_ctrl | hit_status | hit_setf | hit_outf | hit_mon | hit_warn;
  assign wr_en = psel & penable & pwrite & hit_any;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata = prdata_r;

  assign rd_mux = hit_ctrl ? ctrl_r :
                  hit_status ? status_w :
                  hit_setf ? {12'h000, setf_r} :
                  hit_outf ? {12'h000, outf_r} :
                  hit_mon ? {12'h000, mon_r} :
                  hit_warn ? {12'h000, warn_r} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= opmc_pkg::CTRL_RESET;
      setf_r <= '0;
      outf_r <= '0;
      mon_r <= '0;
      warn_r <= '0;
      prdata_r <= 32'h0000_0000;
    end else begin
      if (wr_en && hit_ctrl) ctrl_r <= pwdata & opmc_pkg::CTRL_MASK;
      if (wr_en && hit_setf) setf_r <= pwdata[VW-1:0];
      if (wr_en && hit_outf) outf_r <= pwdata[VW-1:0];
      if (wr_en && hit_mon) mon_r <= pwdata[VW-1:0];
      if (wr_en && hit_warn) warn_r <= pwdata[VW-1:0];
      if (setup_rd) prdata_r <= rd_mux;
    end
  end

  wire stop_any_src = ctrl_r[opmc_pkg::CTRL_STOP_BIT];
  wire jog_reverse = ctrl_r[opmc_pkg::CTRL_JOG_BIT];
  wire custom_display_select_code = ctrl_r[opmc_pkg::CTRL_CUST_BIT];
  wire [opmc_pkg::UNIT_W-1:0] unit_sel =
    ctrl_r[opmc_pkg::CTRL_UNIT_LSB +: opmc_pkg::UNIT_W];

  ////////////////////////////////////////////////////////////////////////////////
  // Blink rates: fast, slow, edit digit
  logic [TW-1:0] tick_cnt_r;
  logic tick;
  logic [2:0] phase;
  localparam int HALF_MS [3] = '{opmc_pkg::FAST_HALF_MS, opmc_pkg::SLOW_HALF_MS,
                                 opmc_pkg::EDIT_HALF_MS};

  assign tick = tick_cnt_r == TW'(TICK_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt_r <= '0;
    else tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
  end

  // Shared millisecond tick keeps the three blink counters small
  for (genvar g = 0; g < 3; g++) begin : g_blink
    logic [opmc_pkg::BLINK_CNT_W-1:0] cnt_r;
    logic ph_r;
    wire wrap = cnt_r == opmc_pkg::BLINK_CNT_W'(HALF_MS[g] - 1);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_r <= '0;
        ph_r <= 1'b0;
      end else if (tick) begin
        cnt_r <= wrap ? '0 : cnt_r + 1'b1;
        if (wrap) ph_r <= ~ph_r;
      end
    end
    assign phase[g] = ph_r;
  end

  wire fast_ph = phase[0];
  wire slow_ph = phase[1];
  wire edit_ph = phase[2];

  ////////////////////////////////////////////////////////////////////////////////
  // Lamps
  opmc_pkg::opmc_lamp_s lamp_nxt;
  wire src_keypad = drive.cmd_src == opmc_pkg::SRC_KEYPAD;

  always_comb begin
    lamp_nxt.run_lamp = drive.running;
    lamp_nxt.control_source_lamp = (drive.cmd_src == opmc_pkg::SRC_TERMINAL) |
      ((drive.cmd_src == opmc_pkg::SRC_COMM) & slow_ph);
    lamp_nxt.direction_lamp = drive.running & drive.dir_fwd;
    // Fault outranks tuning, tuning outranks torque mode
    lamp_nxt.tune_torque_fault_lamp = drive.fault ? fast_ph :
      drive.tuning ? slow_ph : drive.torque_mode;
    lamp_nxt.hz_lamp = unit_sel == opmc_pkg::UNIT_HZ || unit_sel == opmc_pkg::UNIT_RPM;
    lamp_nxt.amp_lamp = unit_sel == opmc_pkg::UNIT_AMP || unit_sel == opmc_pkg::UNIT_RPM ||
      unit_sel == opmc_pkg::UNIT_PCT;
    lamp_nxt.volt_lamp = unit_sel == opmc_pkg::UNIT_VOLT || unit_sel == opmc_pkg::UNIT_PCT;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Menu state
  opmc_pkg::opmc_level_e level_r, level_nxt;
  logic [opmc_pkg::GROUP_W-1:0] group_r, group_nxt;
  logic [opmc_pkg::CODE_W-1:0] code_r, code_nxt;
  logic [VW-1:0] edit_r, edit_nxt;
  logic [2:0] digit_r, digit_nxt;
  logic [1:0] view_r, view_nxt;
  logic [1:0] dmode_r, dmode_nxt;
  logic store_nxt;
  opmc_pkg::opmc_cmd_s cmd_nxt;
  logic editable;
  logic [VW-1:0] step;

  assign editable = ~drive.param_readonly &
    ~(drive.param_stop_only & drive.running);
  assign step = VW'(1) << {digit_r, 2'b00};

  always_comb begin
    level_nxt = level_r;
    group_nxt = group_r;
    code_nxt = code_r;
    edit_nxt = edit_r;
    digit_nxt = digit_r;
    view_nxt = view_r;
    dmode_nxt = dmode_r;
    store_nxt = 1'b0;
    case (level_r)
      opmc_pkg::LVL_STATUS: begin
        if (keys.prog) begin
          level_nxt = opmc_pkg::LVL_GROUP;
        end else if (keys.shift) begin
          view_nxt = view_r == opmc_pkg::VIEW_LAST ? 2'h0 : view_r + 2'h1;
        end
      end
      opmc_pkg::LVL_GROUP: begin
        if (keys.prog) begin
          level_nxt = opmc_pkg::LVL_STATUS;
        end else if (keys.enter) begin
          level_nxt = opmc_pkg::LVL_CODE;
        end else if (keys.up) begin
          group_nxt = group_r + 1'b1;
        end else if (keys.down) begin
          group_nxt = group_r - 1'b1;
        end
      end
      opmc_pkg::LVL_CODE: begin
        if (keys.prog) begin
          level_nxt = opmc_pkg::LVL_GROUP;
        end else if (keys.enter) begin
          level_nxt = opmc_pkg::LVL_VALUE;
          edit_nxt = param_value;
          digit_nxt = 3'h0;
        end else if (keys.up) begin
          code_nxt = code_r + 1'b1;
        end else if (keys.down) begin
          code_nxt = code_r - 1'b1;
        end
      end
      opmc_pkg::LVL_VALUE: begin
        if (keys.prog) begin
          level_nxt = opmc_pkg::LVL_CODE;
        end else if (keys.enter) begin
          level_nxt = opmc_pkg::LVL_CODE;
          store_nxt = editable;
          code_nxt = code_r + 1'b1;
        end else if (keys.shift) begin
          digit_nxt = digit_r == opmc_pkg::DIGIT_LAST ? 3'h0 : digit_r + 3'h1;
        end else if (keys.up && editable) begin
          edit_nxt = edit_r + step;
        end else if (keys.down && editable) begin
          edit_nxt = edit_r - step;
        end
      end
      default: level_nxt = opmc_pkg::LVL_STATUS;
    endcase
    if (keys.mode) begin
      // Without the custom selection only the functional mode exists
      dmode_nxt = !custom_display_select_code ? 2'h0 :
        dmode_r == opmc_pkg::DMODE_LAST ? 2'h0 : dmode_r + 2'h1;
    end
  end

  // Drive commands from the operation keys
  always_comb begin
    cmd_nxt.run_cmd = keys.run & src_keypad;
    cmd_nxt.stop_cmd = keys.stop & drive.running & (src_keypad | stop_any_src);
    cmd_nxt.fault_reset = keys.stop & drive.fault;
    cmd_nxt.jog_cmd = keys.jog & ~jog_reverse & src_keypad;
    cmd_nxt.dir_reverse = keys.jog & jog_reverse;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_r <= opmc_pkg::LVL_STATUS;
      group_r <= '0;
      code_r <= '0;
      edit_r <= '0;
      digit_r <= 3'h0;
      view_r <= 2'h0;
      dmode_r <= 2'h0;
      store_we <= 1'b0;
      store_value <= '0;
      cmds <= '0;
      lamps <= '0;
    end else begin
      level_r <= level_nxt;
      group_r <= group_nxt;
      code_r <= code_nxt;
      edit_r <= edit_nxt;
      digit_r <= digit_nxt;
      view_r <= view_nxt;
      dmode_r <= dmode_nxt;
      store_we <= store_nxt;
      store_value <= edit_r;
      cmds <= cmd_nxt;
      lamps <= lamp_nxt;
    end
  end

  assign sel_group = group_r;
  assign sel_code = code_r;
  assign display_mode = dmode_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Display
  logic [VW-1:0] disp_nxt;
  logic [opmc_pkg::DIGITS-1:0] blank_nxt;
  wire [VW-1:0] status_val = view_r == 2'h0 ? setf_r : view_r == 2'h1 ? outf_r : mon_r;

  always_comb begin
    blank_nxt = '0;
    case (level_r)
      opmc_pkg::LVL_STATUS: disp_nxt = |warn_r ? warn_r : status_val;
      opmc_pkg::LVL_GROUP: disp_nxt = VW'(group_r);
      opmc_pkg::LVL_CODE: disp_nxt = {8'h00, group_r, code_r};
      opmc_pkg::LVL_VALUE: begin
        disp_nxt = edit_r;
        // Locked parameters keep every digit steady
        blank_nxt = (editable & edit_ph) ? opmc_pkg::DIGITS'(1) << digit_r : '0;
      end
      default: disp_nxt = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_value <= '0;
      disp_blank <= '0;
    end else begin
      disp_value <= disp_nxt;
      disp_blank <= blank_nxt;
    end
  end

  assign status_w = (32'(code_r) << opmc_pkg::STAT_CODE_LSB) |
    (32'(group_r) << opmc_pkg::STAT_GROUP_LSB) |
    (32'(level_r) << opmc_pkg::STAT_LEVEL_LSB) |
    (32'(digit_r) << opmc_pkg::STAT_DIGIT_LSB) |
    (32'(dmode_r) << opmc_pkg::STAT_MODE_LSB) |
    (32'(editable) << opmc_pkg::STAT_EDIT_BIT);

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_value_enter;
    level_r == opmc_pkg::LVL_VALUE && keys.enter && !keys.prog;
  endsequence

  sequence s_value_prog;
    level_r == opmc_pkg::LVL_VALUE && keys.prog;
  endsequence

  run_lamp_a: assert property (##1 lamps.run_lamp == $past(drive.running))
    else $error("run lamp does not follow run state");
  src_lamp_a: assert property (drive.cmd_src == opmc_pkg::SRC_KEYPAD |=>
    !lamps.control_source_lamp) else $error("source lamp lit under keypad control");
  dir_lamp_a: assert property (drive.running && drive.dir_fwd |=> lamps.direction_lamp)
    else $error("direction lamp dark while running forward");
  torque_lamp_a: assert property (drive.torque_mode && !drive.fault && !drive.tuning
    |=> lamps.tune_torque_fault_lamp) else $error("torque lamp not steady");
  fault_flash_a: assert property (drive.fault |=>
    lamps.tune_torque_fault_lamp == $past(fast_ph)) else $error("fault lamp not fast");
  unit_rpm_a: assert property (unit_sel == opmc_pkg::UNIT_RPM |=>
    lamps.hz_lamp && lamps.amp_lamp && !lamps.volt_lamp) else $error("speed unit lamps");
  prog_enter_a: assert property (level_r == opmc_pkg::LVL_STATUS && keys.prog |=>
    level_r == opmc_pkg::LVL_GROUP) else $error("programming key did not enter menu");
  enter_store_a: assert property (s_value_enter ##0 editable |=> store_we &&
    level_r == opmc_pkg::LVL_CODE && code_r == $past(code_r) + 1'b1)
    else $error("enter did not store and advance");
  prog_nosave_a: assert property (s_value_prog |=> !store_we &&
    level_r == opmc_pkg::LVL_CODE && $stable(code_r)) else $error("exit stored value");
  run_key_a: assert property (keys.run && drive.cmd_src != opmc_pkg::SRC_KEYPAD |=>
    !cmds.run_cmd) else $error("run key honoured off keypad");
  lock_edit_a: assert property (level_r == opmc_pkg::LVL_VALUE && !editable |=>
    $stable(edit_r) && !store_we ##1 disp_blank == '0)
    else $error("locked parameter changed or flashed");
  stop_only_a: assert property (drive.running && drive.param_stop_only &&
    level_r == opmc_pkg::LVL_VALUE && (keys.up || keys.down) |=> $stable(edit_r))
    else $error("stop-only parameter edited while running");

endmodule
`default_nettype wire

// ---- opmc_keypad.sv ----
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Keypad, lamps and display as the operator sees them
module opmc_keypad (
  input wire logic clk,
  input wire opmc_pkg::opmc_lamp_s lamps,
  input wire logic [opmc_pkg::DIGITS-1:0] disp_blank,
  output var opmc_pkg::opmc_key_s keys
);
  logic [11:0] seen;
  assign seen = {lamps, disp_blank};
  initial keys = '0;
  // One pulse per press, held for one clock and released on the edge that samples it
  task automatic press(input opmc_pkg::opmc_key_s k);
    @(posedge clk);
    keys <= k;
    @(posedge clk);
    keys <= '0;
  endtask
  // Cycles between two changes; a steady light gives the bound
  task automatic half(input int b, output int n);
    logic v;
    int i;
    n = 0;
    @(posedge clk);
    #1;
    v = seen[b];
    for (i = 0; i < 5000 && seen[b] == v; i++) begin
      @(posedge clk);
      #1;
    end
    v = seen[b];
    for (i = 0; i < 5000 && seen[b] == v; i++) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
endmodule
`default_nettype wire

// ---- opmc_panel_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module opmc_panel_tb_top;
  localparam int TK = 4;
  localparam logic [8:0] K_PROG = 9'h100, K_ENTER = 9'h080, K_UP = 9'h040, K_DOWN = 9'h020;
  localparam logic [8:0] K_SHIFT = 9'h010, K_RUN = 9'h008, K_STOP = 9'h004, K_MODE = 9'h002;
  localparam logic [8:0] K_JOG = 9'h001, D_RUN = 9'h100, D_FAULT = 9'h080, D_TUNE = 9'h040;
  localparam logic [8:0] D_TORQ = 9'h020, D_FWD = 9'h010, D_COMM = 9'h008, D_TERM = 9'h004;
  localparam logic [8:0] D_RO = 9'h002, D_SO = 9'h001;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, store_we, err;
  logic [opmc_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, c;
  logic [19:0] param_value, disp_value, store_value, v;
  logic [19:0] vw [3];
  logic [4:0] disp_blank;
  logic [3:0] sel_group;
  logic [7:0] sel_code;
  logic [1:0] display_mode, src;
  logic [8:0] k;
  opmc_pkg::opmc_key_s keys;
  opmc_pkg::opmc_drive_s drv;
  opmc_pkg::opmc_lamp_s lamps;
  opmc_pkg::opmc_cmd_s cmds;
  int err_total, n_compared, seed, n, i;

  opmc_panel #(.TICK_CYCLES(TK)) opmc_panel_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .keys(keys), .drive(drv), .param_value(param_value),
    .lamps(lamps), .cmds(cmds), .disp_value(disp_value), .disp_blank(disp_blank),
    .sel_group(sel_group), .sel_code(sel_code), .store_we(store_we),
    .store_value(store_value), .display_mode(display_mode));
  opmc_keypad opmc_keypad_i (.clk(pclk), .lamps(lamps), .disp_blank(disp_blank), .keys(keys));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (j = 0; j < 20; j++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (j == 20) begin
      err_total++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cyc(input int m);
    repeat (m) @(posedge pclk);
    #1;
  endtask
  task automatic setd(input logic [8:0] d);
    @(posedge pclk);
    drv <= d;
    cyc(3);
  endtask
  task automatic pk(input logic [8:0] kk);
    opmc_keypad_i.press(kk);
    #1;
  endtask
  task automatic lvl(input logic [1:0] e);
    apb(1'b0, opmc_pkg::REG_STATUS, 32'h0);
    check(rd[13:12], e);
  endtask
  task automatic still(input int b, input logic val, input int m);
    int bad;
    bad = 0;
    repeat (m) begin
      @(posedge pclk);
      #1;
      if (opmc_keypad_i.seen[b] !== val) bad++;
    end
    check(bad, 0);
  endtask
  function automatic logic [2:0] uexp(input int u);
    case (u)
      0: uexp = 3'h4;
      1: uexp = 3'h2;
      2: uexp = 3'h1;
      3: uexp = 3'h6;
      4: uexp = 3'h3;
      default: uexp = 3'h0;
    endcase
  endfunction
  // Stop scope bit 0 widens stop beyond keypad; jog bit 1 turns jog into reversal
  function automatic logic [4:0] ecmd(input logic [1:0] key, input logic [1:0] s,
      input logic [1:0] cf, input logic run, input logic flt);
    ecmd = '0;
    if (key == 2'h0) ecmd[4] = (s == 2'h0);
    else if (key == 2'h1) ecmd[3:2] = {run && (s == 2'h0 || cf[0]), flt};
    else if (cf[1]) ecmd[0] = 1'b1;
    else ecmd[1] = (s == 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard, well beyond the longest sequence
  initial begin
    #1000000;
    err_total++;
    results();
  end
  initial begin
    err_total = 0;
    n_compared = 0;
    seed = 32'h159d5437;
    {psel, penable, pwrite, paddr, pwdata, param_value, presetn} = '0;
    drv = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    check({lamps, cmds, store_we}, {4'h0, uexp(0), 6'h00});
    apb(1'b0, opmc_pkg::REG_CTRL, 32'h0);
    check(rd, opmc_pkg::CTRL_RESET);
    apb(1'b1, opmc_pkg::REG_CTRL, 32'hFFFF_FFFF);
    apb(1'b0, opmc_pkg::REG_CTRL, 32'h0);
    check(rd, opmc_pkg::CTRL_MASK);
    apb(1'b1, opmc_pkg::REG_STATUS, 32'hFFFF_FFFF);
    lvl(2'h0);
    apb(1'b0, 8'h18, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    // Lamps
    setd(D_RUN | D_FWD);
    check({lamps.run_lamp, lamps.direction_lamp}, 2'h3);
    setd(D_RUN);
    check({lamps.run_lamp, lamps.direction_lamp}, 2'h2);
    setd(D_TERM);
    check({lamps.run_lamp, lamps.control_source_lamp}, 2'h1);
    setd(9'h000);
    check(lamps.control_source_lamp, 0);
    setd(D_COMM);
    opmc_keypad_i.half(10, n);
    check(n, 500 * TK);
    setd(D_TORQ);
    still(8, 1'b1, 600);
    setd(D_TUNE);
    opmc_keypad_i.half(8, n);
    check(n, 500 * TK);
    setd(D_FAULT | D_TUNE);
    opmc_keypad_i.half(8, n);
    check(n, 100 * TK);
    setd(9'h000);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, opmc_pkg::REG_CTRL, 32'(i) << opmc_pkg::CTRL_UNIT_LSB);
      cyc(2);
      check({lamps.hz_lamp, lamps.amp_lamp, lamps.volt_lamp}, uexp(i));
    end
    apb(1'b1, opmc_pkg::REG_CTRL, 32'h0);
    // Status screen: views and warning
    for (i = 0; i < 3; i++) begin
      vw[i] = 20'($random(seed));
      apb(1'b1, opmc_pkg::REG_SETF + 8'(4 * i), {12'hFFF, vw[i]});
    end
    apb(1'b0, opmc_pkg::REG_OUTF, 32'h0);
    check(rd, {12'h000, vw[1]});
    for (i = 0; i < 4; i++) begin
      cyc(2);
      check(disp_value, vw[i % 3]);
      if (i < 3) pk(K_SHIFT);
    end
    v = 20'($random(seed)) | 20'h0_0001;
    apb(1'b1, opmc_pkg::REG_WARN, {12'h000, v});
    cyc(2);
    check(disp_value, v);
    apb(1'b1, opmc_pkg::REG_WARN, 32'h0);
    // Menu walk
    pk(K_PROG);
    lvl(2'h1);
    pk(K_PROG);
    lvl(2'h0);
    pk(K_PROG);
    pk(K_DOWN);
    check(sel_group, 4'hF);
    pk(K_UP);
    pk(K_UP);
    cyc(2);
    check({sel_group, disp_value[3:0]}, 8'h11);
    pk(K_ENTER);
    lvl(2'h2);
    check(disp_value, 20'h0_0100);
    pk(K_DOWN);
    check(sel_code, 8'hFF);
    pk(K_UP);
    pk(K_UP);
    v = 20'($random(seed));
    @(posedge pclk);
    param_value <= v;
    pk(K_ENTER);
    lvl(2'h3);
    check(disp_value, v);
    pk(K_UP);
    pk(K_SHIFT);
    pk(K_UP);
    apb(1'b0, opmc_pkg::REG_STATUS, 32'h0);
    check({rd[24], rd[18:16]}, 4'h9);
    check(disp_value, 20'(v + 20'h0_0011));
    opmc_keypad_i.half(1, n);
    check(n, 250 * TK);
    pk(K_ENTER);
    check({store_we, sel_code, store_value}, {1'b1, 8'h02, 20'(v + 20'h0_0011)});
    lvl(2'h2);
    pk(K_ENTER);
    pk(K_UP);
    pk(K_PROG);
    check({store_we, sel_code}, 9'h002);
    lvl(2'h2);
    // Locked parameters
    setd(D_RO);
    pk(K_ENTER);
    pk(K_UP);
    still(0, 1'b0, 1100);
    check(disp_value, v);
    pk(K_ENTER);
    check({store_we, sel_code}, 9'h003);
    setd(D_RUN | D_SO);
    pk(K_ENTER);
    pk(K_UP);
    cyc(2);
    check({disp_blank, disp_value}, {5'h00, v});
    pk(K_PROG);
    setd(D_SO);
    pk(K_ENTER);
    pk(K_UP);
    cyc(2);
    check(disp_value, 20'(v + 20'h0_0001));
    pk(K_PROG);
    // Display modes
    pk(K_MODE);
    check(display_mode, 0);
    apb(1'b1, opmc_pkg::REG_CTRL, 32'h0000_0004);
    for (i = 1; i < 4; i++) begin
      pk(K_MODE);
      check(display_mode, i % 3);
    end
    // Run, stop and jog under random source and configuration
    for (i = 0; i < 40; i++) begin
      c = $random(seed);
      src = (c[7:6] == 2'h3) ? 2'h0 : c[7:6];
      k = (c[9:8] == 2'h0) ? K_RUN : (c[9:8] == 2'h1) ? K_STOP : K_JOG;
      apb(1'b1, opmc_pkg::REG_CTRL, {30'h0, c[1:0]});
      setd({c[4], c[5], 3'h0, src, 2'h0});
      pk(k);
      check(cmds, ecmd(c[9:8], src, c[1:0], c[4], c[5]));
    end
    results();
  end
endmodule
`default_nettype wire
